// *** hw/jtc_params.svh ***
// Register map, control field positions and coding constants
// for the in-frame response transmit control block.
// Assumes an 8-bit register address and an external symbol layer.
`ifndef JTC_PARAMS_SVH
`define JTC_PARAMS_SVH

// --------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------
`define JTC_ADDR_SVEC 8'h3d
`define JTC_ADDR_CTRL 8'h3e
`define JTC_ADDR_DATA 8'h3f

// --------------------------------------------------------------
// Fields of transmit_control
// --------------------------------------------------------------
`define JTC_B_QUAD 7
`define JTC_B_NORM 6
`define JTC_B_EODR 3
`define JTC_B_SIFR 2
`define JTC_B_MIFR1 1
`define JTC_B_MIFR0 0
`define JTC_CTRL_RST 8'h00
`define JTC_CTRL_MASK 8'hcf

// --------------------------------------------------------------
// State vector codes
// --------------------------------------------------------------
`define JTC_SV_NONE 8'h00
`define JTC_SV_EMPTY 8'h10
`define JTC_SV_ARB 8'h14
`define JTC_SV_SYM 8'h1c

// --------------------------------------------------------------
// Frame check and bit positions
// --------------------------------------------------------------
`define JTC_CRC_POLY 8'h1d
`define JTC_CRC_INIT 8'hff
`define JTC_BIT_LAST 3'h7
`define JTC_BIT_LATE 3'h6
`define JTC_ONES_LAST 1'h1

`endif

// *** hw/jtc_pkg.sv ***
// Types shared by the in-frame response transmit control block.
// Assumes the constants header is included where numbers are needed.
package jtc_pkg;

    // ----------------------------------------------------------
    // Link carriers
    // ----------------------------------------------------------
    typedef struct packed {
        logic sym_tick;  // One pulse at the end of each bit time
        logic rx_bit;    // Resolved bus bit of the ending bit time
        logic eod_seen;  // Valid end-of-data symbol observed
        logic crc_err;   // Frame before that symbol had a bad check
        logic eof_seen;  // End of frame observed
        logic bus_error; // Symbol or framing error on the bus
    } jtc_link_in_t;

    typedef struct packed {
        logic en;        // Drive a data bit this bit time
        logic bit_val;   // Logic value of the driven bit
        logic eod;       // Hold passive for an end-of-data symbol
    } jtc_link_out_t;

    // ----------------------------------------------------------
    // Modes and sequencer states
    // ----------------------------------------------------------
    typedef enum logic [1:0] {
        M_NONE, M_SINGLE, M_CRC, M_PLAIN
    } jtc_mode_t;

    typedef enum logic [2:0] {
        S_IDLE, S_NB, S_DATA, S_CRC, S_ONES, S_EOD, S_RETRY
    } jtc_state_t;

endpackage

// *** hw/jtc_tx_ctrl.sv ***
// In-frame response transmit control of a byte-level link
// controller: control register, data shadow and response sequencer.
// Assumes a symbol layer that times bits and reports bus symbols.
`timescale 1ns/1ps

module jtc_tx_ctrl
    import jtc_pkg::*;
(
    input wire logic clk,              // System clock
    input wire logic srst,             // Synchronous reset, high
    input wire logic [7:0] addr,       // Register address
    input wire logic [7:0] wdata,      // Register write data
    input wire logic wr,               // Write strobe
    input wire logic rd,               // Read strobe
    output logic [7:0] rdata,          // Read data, cycle after rd
    input wire jtc_link_in_t lnk,      // Symbol layer events
    output jtc_link_out_t tx,          // Transmit request to bus
    output logic quad_rate,            // Quad rate receive selected
    output logic tx_empty,             // Transmit data empty
    output logic lost_arb,             // Arbitration lost flag
    output logic underrun              // Transmitter underrun flag
);
`include "jtc_params.svh"

    // ----------------------------------------------------------
    // Declarations and functions
    // ----------------------------------------------------------
    logic [7:0] ctrl_q, shadow_q, shift_q, crc_q, rdata_q, crc_nx;
    logic [2:0] bit_q;
    logic shadow_full_q, after_eod_q, empty_q, lost_q, unr_q;
    jtc_link_out_t tx_q;
    jtc_state_t state_q;
    jtc_mode_t mode_q, req_mode;
    logic tick, lose, late, byte_end, multi, start;
    logic ev_ok_single, ev_lost_multi, ev_unr, ev_eod_back;
    logic clr_req, clr_eodr, empty_set, wr_ctrl, wr_data, rd_sv;

    // Priority resolve of the three response request bits
    function automatic jtc_mode_t resolve(input logic [2:0] r);
        return r[2] ? M_SINGLE : r[1] ? M_CRC : r[0] ? M_PLAIN : M_NONE;
    endfunction

    // One serial step of the frame check
    function automatic logic [7:0] crc_step(input logic [7:0] c,
                                            input logic b);
        logic fb;
        fb = c[7] ^ b;
        return {c[6:0], 1'b0} ^ (fb ? `JTC_CRC_POLY : 8'h00);
    endfunction

    // ----------------------------------------------------------
    // Event decode
    // ----------------------------------------------------------
    // Reads of the control register keep the raw pattern; only the
    // sequencer sees the resolved mode.
    assign req_mode = resolve(ctrl_q[`JTC_B_SIFR:`JTC_B_MIFR0]);
    assign wr_ctrl = wr && (addr == `JTC_ADDR_CTRL);
    assign wr_data = wr && (addr == `JTC_ADDR_DATA);
    assign rd_sv = rd && (addr == `JTC_ADDR_SVEC);
    assign tick = lnk.sym_tick;
    assign multi = (mode_q == M_CRC) || (mode_q == M_PLAIN);
    assign lose = (state_q == S_DATA) && tick
                  && (lnk.rx_bit != tx_q.bit_val);
    assign late = (bit_q >= `JTC_BIT_LATE);
    assign byte_end = (state_q == S_DATA) && tick && !lose
                      && (bit_q == `JTC_BIT_LAST);
    assign crc_nx = crc_step(crc_q, tx_q.bit_val);
    // Quad rate blocks every response start
    assign start = (state_q == S_IDLE) && lnk.eod_seen
                   && !lnk.crc_err && (req_mode != M_NONE)
                   && !ctrl_q[`JTC_B_QUAD];
    assign ev_ok_single = byte_end && (mode_q == M_SINGLE);
    assign ev_lost_multi = lose && multi;
    assign ev_unr = byte_end && multi && !shadow_full_q
                    && !ctrl_q[`JTC_B_EODR];
    assign ev_eod_back = (state_q == S_EOD) && lnk.eod_seen;
    assign clr_req = lnk.bus_error || ev_ok_single
                     || ev_lost_multi || ev_unr
                     || ev_eod_back;
    assign clr_eodr = lnk.bus_error || ev_eod_back;
    // First bit of a byte from the shadow has gone out
    assign empty_set = (state_q == S_DATA) && tick && multi
                       && (bit_q == 3'h0) && !lose;

    // ----------------------------------------------------------
    // Control register and end-of-data window
    // ----------------------------------------------------------
    // Marks the span between an end-of-data symbol and frame end
    always_ff @(posedge clk) begin
        if (srst)
            after_eod_q <= 1'b0;
        else if (lnk.eod_seen)
            after_eod_q <= 1'b1;
        else if (lnk.eof_seen)
            after_eod_q <= 1'b0;
    end

    // Hardware clears are applied after the write so that a
    // finished response never leaves a stale request behind.
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= `JTC_CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= wdata & `JTC_CTRL_MASK;
                // Too late to join this response
                if (after_eod_q && state_q == S_IDLE)
                    ctrl_q[`JTC_B_SIFR:`JTC_B_MIFR0] <= 3'h0;
                if (wdata[`JTC_B_EODR])
                    ctrl_q[`JTC_B_SIFR] <= 1'b0;
            end
            if (clr_req)
                ctrl_q[`JTC_B_SIFR:`JTC_B_MIFR0] <= 3'h0;
            if (clr_eodr)
                ctrl_q[`JTC_B_EODR] <= 1'b0;
        end
    end

    // ----------------------------------------------------------
    // Data shadow and status flags
    // ----------------------------------------------------------
    // Single mode leaves the shadow full so a retry can reuse it
    always_ff @(posedge clk) begin
        if (srst) begin
            shadow_q <= 8'h00;
            shadow_full_q <= 1'b0;
        end else if (wr_data) begin
            shadow_q <= wdata;
            shadow_full_q <= 1'b1;
        end else if (multi && (byte_end || (state_q == S_NB && tick)))
            shadow_full_q <= 1'b0;
    end

    // Hardware set wins over any clear in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            empty_q <= 1'b0;
            lost_q <= 1'b0;
            unr_q <= 1'b0;
        end else begin
            if (empty_set)
                empty_q <= 1'b1;
            else if (wr_data || lnk.bus_error
                     || (wr_ctrl && wdata[`JTC_B_EODR]))
                empty_q <= 1'b0;
            if (ev_lost_multi)
                lost_q <= 1'b1;
            else if (rd_sv)
                lost_q <= 1'b0;
            if (ev_unr)
                unr_q <= 1'b1;
            else if (rd_sv)
                unr_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------
    // Response sequencer
    // ----------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= S_IDLE;
            mode_q <= M_NONE;
            shift_q <= 8'h00;
            bit_q <= 3'h0;
            crc_q <= `JTC_CRC_INIT;
            tx_q <= '0;
        end else if (lnk.bus_error) begin
            state_q <= S_IDLE;
            mode_q <= M_NONE;
            tx_q <= '0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    tx_q <= '0;
                    if (start) begin
                        state_q <= S_NB;
                        mode_q <= req_mode;
                        tx_q.en <= 1'b1;
                        // Format select flips the sense per kind
                        tx_q.bit_val <= ctrl_q[`JTC_B_NORM]
                                        ^ (req_mode == M_CRC);
                    end
                end
                S_NB: begin
                    if (tick) begin
                        state_q <= S_DATA;
                        shift_q <= {shadow_q[6:0], 1'b0};
                        tx_q.bit_val <= shadow_q[7];
                        bit_q <= 3'h0;
                        crc_q <= `JTC_CRC_INIT;
                    end
                end
                S_DATA: begin
                    if (lose && mode_q == M_SINGLE) begin
                        // Shifting byte is queued, so no ones
                        state_q <= S_RETRY;
                        tx_q.en <= 1'b0;
                        bit_q <= bit_q + 3'h1;
                    end else if (lose) begin
                        mode_q <= M_NONE;
                        bit_q <= 3'h0;
                        state_q <= late ? S_ONES : S_IDLE;
                        tx_q.en <= late;
                        tx_q.bit_val <= 1'b1;
                    end else if (tick) begin
                        crc_q <= crc_nx;
                        bit_q <= bit_q + 3'h1;
                        shift_q <= {shift_q[6:0], 1'b0};
                        tx_q.bit_val <= shift_q[7];
                        if (byte_end) begin
                            bit_q <= 3'h0;
                            if (mode_q == M_SINGLE) begin
                                state_q <= S_IDLE;
                                tx_q <= '0;
                            end else if (shadow_full_q) begin
                                // Shadow byte goes before the check
                                shift_q <= {shadow_q[6:0], 1'b0};
                                tx_q.bit_val <= shadow_q[7];
                            end else if (ctrl_q[`JTC_B_EODR]
                                         && mode_q == M_CRC) begin
                                state_q <= S_CRC;
                                shift_q <= {~crc_nx[6:0], 1'b0};
                                tx_q.bit_val <= ~crc_nx[7];
                            end else if (ctrl_q[`JTC_B_EODR]) begin
                                state_q <= S_EOD;
                                tx_q.en <= 1'b0;
                                tx_q.eod <= 1'b1;
                            end else begin
                                // Underrun forces a byte fault
                                state_q <= S_ONES;
                                tx_q.bit_val <= 1'b1;
                            end
                        end
                    end
                end
                S_CRC: begin
                    if (tick) begin
                        bit_q <= bit_q + 3'h1;
                        shift_q <= {shift_q[6:0], 1'b0};
                        tx_q.bit_val <= shift_q[7];
                        if (bit_q == `JTC_BIT_LAST) begin
                            state_q <= S_EOD;
                            tx_q.en <= 1'b0;
                            tx_q.eod <= 1'b1;
                        end
                    end
                end
                S_ONES: begin
                    if (tick) begin
                        bit_q <= bit_q + 3'h1;
                        if (bit_q[0] == `JTC_ONES_LAST) begin
                            state_q <= S_IDLE;
                            mode_q <= M_NONE;
                            tx_q <= '0;
                        end
                    end
                end
                S_EOD: begin
                    if (lnk.eod_seen) begin
                        state_q <= S_IDLE;
                        mode_q <= M_NONE;
                        tx_q <= '0;
                    end
                end
                S_RETRY: begin
                    // Give up once the request has been withdrawn
                    if (req_mode != M_SINGLE) begin
                        state_q <= S_IDLE;
                        mode_q <= M_NONE;
                    end else if (tick) begin
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == `JTC_BIT_LAST) begin
                            // Retry carries no normalization bit
                            state_q <= S_DATA;
                            bit_q <= 3'h0;
                            crc_q <= `JTC_CRC_INIT;
                            shift_q <= {shadow_q[6:0], 1'b0};
                            tx_q.en <= 1'b1;
                            tx_q.bit_val <= shadow_q[7];
                        end
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                    tx_q <= '0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------
    // Register readback and outputs
    // ----------------------------------------------------------
    // Unmapped addresses and idle cycles read as zero
    always_ff @(posedge clk) begin
        if (srst || !rd)
            rdata_q <= 8'h00;
        else if (addr == `JTC_ADDR_CTRL)
            rdata_q <= ctrl_q;
        else if (addr == `JTC_ADDR_DATA)
            rdata_q <= shadow_q;
        else if (addr == `JTC_ADDR_SVEC)
            rdata_q <= unr_q ? `JTC_SV_SYM : lost_q ? `JTC_SV_ARB
                       : empty_q ? `JTC_SV_EMPTY : `JTC_SV_NONE;
        else
            rdata_q <= 8'h00;
    end

    assign rdata = rdata_q;
    assign tx = tx_q;
    assign quad_rate = ctrl_q[`JTC_B_QUAD];
    assign tx_empty = empty_q;
    assign lost_arb = lost_q;
    assign underrun = unr_q;

endmodule

// *** verification/jtc_bus_model.sv ***
// Bus-side model: bit ticks, echo of our end symbol, injected events.
// Assumes the bench pulses its request inputs for one cycle.
`timescale 1ns/1ps

module jtc_bus_model
    import jtc_pkg::*;
(
    input wire logic clk,          // System clock
    input wire logic srst,         // Synchronous reset
    input wire jtc_link_out_t tx,  // Transmit request
    input wire logic eod_req,      // Foreign frame reaches end of data
    input wire logic eof_req,      // Frame ends
    input wire logic err_req,      // Inject a bus error
    input wire logic crc_bad,      // Foreign frame had a bad check
    input wire logic lose,         // A rival wins every driven bit
    output jtc_link_in_t lnk       // Events to the block
);
    // ------------------------------------------------------
    // Bit timing and bus level
    // ------------------------------------------------------
    logic [1:0] cnt_q;

    // Four clocks per bit keeps the run short
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end

    // Undriven bus is passive, pulled to 0
    always_comb begin
        lnk.sym_tick = cnt_q == 2'h3;
        lnk.rx_bit = tx.en ? tx.bit_val ^ lose : 1'b0;
        lnk.eod_seen = eod_req | (tx.eod & (cnt_q == 2'h3));
        lnk.crc_err = crc_bad;
        lnk.eof_seen = eof_req;
        lnk.bus_error = err_req;
    end
endmodule

// *** verification/jtc_tx_monitor.sv ***
// Port-level assertions for the response transmit control block.
// Assumes it is bound onto the design top by the bench.
`timescale 1ns/1ps
`include "jtc_params.svh"

module jtc_tx_monitor
    import jtc_pkg::*;
(
    input wire logic clk,          // System clock
    input wire logic srst,         // Synchronous reset
    input wire logic [7:0] addr,   // Register address
    input wire logic [7:0] wdata,  // Write data
    input wire logic wr,           // Write strobe
    input wire logic rd,           // Read strobe
    input wire logic [7:0] rdata,  // Read data
    input wire jtc_link_in_t lnk,  // Symbol layer events
    input wire jtc_link_out_t tx,  // Transmit request
    input wire logic quad_rate,    // Quad rate selected
    input wire logic tx_empty,     // Data empty flag
    input wire logic lost_arb,     // Lost flag
    input wire logic underrun      // Underrun flag
);
    // ------------------------------------------------------
    // Helpers
    // ------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire sv_rd = rd && addr == `JTC_ADDR_SVEC;
    wire good_eod = lnk.eod_seen && !lnk.crc_err;

    // ------------------------------------------------------
    // Relations between ports
    // ------------------------------------------------------
    a_quad_silent: assert property ($rose(tx.en) |-> !$past(quad_rate))
        else $error("transmit started in quad rate");
    a_eod_empty: assert property (wr && addr == `JTC_ADDR_CTRL && wdata[3]
        |=> !tx_empty) else $error("end request left data empty set");
    a_eod_release: assert property (tx.eod && lnk.eod_seen |=> !tx.eod)
        else $error("end symbol held after echo");
    a_start_cause: assert property ($rose(tx.en) |->
        $past(good_eod) || $past(lnk.sym_tick))
        else $error("drive began without a cause");
    a_bit_hold: assert property (tx.en && $past(tx.en) &&
        !$past(lnk.sym_tick) |-> $stable(tx.bit_val))
        else $error("bit changed inside a bit time");
    a_error_abort: assert property (lnk.bus_error |=>
        !tx.en && !tx.eod) else $error("bus error did not abort");
    a_lost_stop: assert property ($rose(lost_arb) |-> ##[0:12] !tx.en)
        else $error("drive went on after loss");
    a_fall_cause: assert property ($fell(tx.en) |->
        $past(lnk.sym_tick) || $past(lnk.bus_error))
        else $error("drive dropped off a bit boundary");
    a_vec_clear: assert property (sv_rd && !lnk.sym_tick |=>
        !lost_arb && !underrun) else $error("vector read kept flags");
    a_vec_lost: assert property (sv_rd && lost_arb && !underrun |=>
        rdata == `JTC_SV_ARB) else $error("wrong loss code");
    a_vec_under: assert property (sv_rd && underrun |=>
        rdata == `JTC_SV_SYM) else $error("wrong underrun code");

    // Main scenarios reached
    c_lost: cover property ($rose(lost_arb));
    c_under: cover property ($rose(underrun));
    c_echo: cover property (tx.eod && lnk.eod_seen);
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the response transmit control block.
// Assumes the bus model on the link side and the bound monitor.
`timescale 1ns/1ps
`include "jtc_params.svh"

module testbench;
    import jtc_pkg::*;
    // ------------------------------------------------------
    // Signals, rows and helpers
    // ------------------------------------------------------
    logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, lose = 1'b0;
    logic eod_req = 1'b0, eof_req = 1'b0, err_req = 1'b0, crc_bad = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, ncap = 8'h00;
    logic [7:0] rdata, got, c, n;
    logic [16:0] cap = '0;
    logic quad_rate, tx_empty, lost_arb, underrun;
    jtc_link_in_t lnk;
    jtc_link_out_t tx;
    int mismatches = 0, tests_run = 0, i;
    // Control, data, control readback, normalization bit
    logic [31:0] rows [9] = '{32'h04a5_0400, 32'h44a5_4401,
        32'h025b_0201, 32'h425b_4200, 32'h01c3_0100, 32'h41c3_4101,
        32'h0796_0700, 32'h4396_4300, 32'h3569_0500};

    jtc_tx_ctrl u_jtc_tx_ctrl (.clk(clk), .srst(srst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .lnk(lnk),
        .tx(tx), .quad_rate(quad_rate), .tx_empty(tx_empty),
        .lost_arb(lost_arb), .underrun(underrun));
    jtc_bus_model u_jtc_bus_model (.clk(clk), .srst(srst), .tx(tx),
        .eod_req(eod_req), .eof_req(eof_req), .err_req(err_req),
        .crc_bad(crc_bad), .lose(lose), .lnk(lnk));

    initial begin
        forever #4 clk = ~clk;
    end

    // Record each driven bit at the tick that ends it
    always @(posedge clk) begin
        if (lnk.sym_tick && tx.en) begin
            cap <= {cap[15:0], tx.bit_val};
            ncap <= ncap + 8'h01;
        end
    end

    task automatic chk_byte(input logic [7:0] g, e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask

    task automatic chk_bits(input logic [16:0] g, e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %0t stream %h want %h", $time, g, e);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic reg_rd(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        got = rdata;
        @(posedge clk);
    endtask

    // Event pulse to the bus model: 0 end of data, 1 frame end, 2 error
    task automatic pulse(input int k);
        eod_req <= k == 0;
        eof_req <= k == 1;
        err_req <= k == 2;
        @(posedge clk);
        {eod_req, eof_req, err_req} <= 3'b000;
        @(posedge clk);
    endtask

    // Load, arm, read the control back, then signal end of data on a foreign frame
    task automatic launch(input logic [7:0] cv, d);
        reg_wr(`JTC_ADDR_DATA, d);
        reg_wr(`JTC_ADDR_CTRL, cv);
        reg_rd(`JTC_ADDR_CTRL);
        cap = '0;
        ncap = 8'h00;
        pulse(0);
    endtask

    task automatic silent(input logic [7:0] cv, input logic bad);
        crc_bad <= bad;
        launch(cv, 8'h55);
        repeat (40) @(posedge clk);
        chk_byte(ncap, 8'h00);
        reg_wr(`JTC_ADDR_CTRL, 8'h00);
        crc_bad <= 1'b0;
        pulse(1);
    endtask

    // Inverted check byte, seed all ones, MSB first
    function automatic logic [7:0] crc8(input logic [7:0] d);
        logic [7:0] r;
        r = 8'hff;
        for (int b = 7; b >= 0; b--) begin
            r = {r[6:0], 1'b0} ^ ((r[7] ^ d[b]) ? 8'h1d : 8'h00);
        end
        return ~r;
    endfunction

    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Hang guard, well past the thousand or so cycles needed
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        final_report;
    end

    // ------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        foreach (rows[r]) begin
            c = rows[r][31:24];
            n = (c[1] && !c[2]) ? 8'd17 : 8'd9;
            launch(c, rows[r][23:16]);
            chk_byte(got, rows[r][15:8]);
            if (!c[2]) begin
                for (i = 0; i < 99 && !tx_empty; i++) @(posedge clk);
                reg_wr(`JTC_ADDR_CTRL, c | 8'h08);
                #1;
                chk_byte({7'h00, tx_empty}, 8'h00);
            end
            for (i = 0; i < 400 && (tx.en || tx.eod || ncap < n); i++)
                @(posedge clk);
            #1;
            chk_bits(cap, n == 8'd17 ? {rows[r][0], rows[r][23:16],
                crc8(rows[r][23:16])} : {8'h00, rows[r][0], rows[r][23:16]});
            chk_byte(ncap, n);
            reg_rd(`JTC_ADDR_CTRL);
            chk_byte(got, c & 8'h40);
            pulse(1);
            $display("row %0d done", r);
        end
        silent(8'h84, 1'b0);
        silent(8'h04, 1'b1);
        pulse(0);
        reg_wr(`JTC_ADDR_CTRL, 8'h04);
        reg_rd(`JTC_ADDR_CTRL);
        chk_byte(got, 8'h00);
        pulse(1);
        $display("silent cases done");
        // Rival wins mid-byte, clear of the last two bits
        launch(8'h01, 8'hf0);
        for (i = 0; i < 99 && !tx_empty; i++) @(posedge clk);
        repeat (8) @(posedge clk);
        lose <= 1'b1;
        for (i = 0; i < 99 && !lost_arb; i++) @(posedge clk);
        lose <= 1'b0;
        repeat (12) @(posedge clk);
        #1;
        chk_byte({7'h00, tx.en}, 8'h00);
        reg_rd(`JTC_ADDR_SVEC);
        chk_byte(got, `JTC_SV_ARB);
        reg_rd(`JTC_ADDR_SVEC);
        chk_byte(got, `JTC_SV_EMPTY);
        reg_rd(`JTC_ADDR_CTRL);
        chk_byte(got, 8'h00);
        reg_wr(`JTC_ADDR_DATA, 8'h11);
        reg_rd(`JTC_ADDR_SVEC);
        chk_byte(got, `JTC_SV_NONE);
        pulse(1);
        $display("loss case done");
        // No second byte and no end request: underrun
        launch(8'h02, 8'h3c);
        for (i = 0; i < 200 && !underrun; i++) @(posedge clk);
        repeat (12) @(posedge clk);
        chk_bits(cap, {6'h00, 1'b1, 8'h3c, 2'b11});
        reg_rd(`JTC_ADDR_SVEC);
        chk_byte(got, `JTC_SV_SYM);
        reg_rd(`JTC_ADDR_CTRL);
        chk_byte(got, 8'h00);
        pulse(1);
        // Bus error in mid byte
        launch(8'h04, 8'h5a);
        for (i = 0; i < 99 && ncap < 3; i++) @(posedge clk);
        pulse(2);
        reg_rd(`JTC_ADDR_CTRL);
        chk_byte(got, 8'h00);
        pulse(1);
        $display("underrun and error done");
        // Reset in mid run, then an unmapped read
        reg_wr(`JTC_ADDR_CTRL, 8'hc0);
        srst <= 1'b1;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        reg_rd(`JTC_ADDR_CTRL);
        chk_byte(got, `JTC_CTRL_RST);
        reg_rd(8'h10);
        chk_byte(got, 8'h00);
        $display("reset done");
        final_report;
    end
endmodule

bind jtc_tx_ctrl jtc_tx_monitor u_jtc_tx_monitor (.clk(clk), .srst(srst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .lnk(lnk), .tx(tx), .quad_rate(quad_rate), .tx_empty(tx_empty),
    .lost_arb(lost_arb), .underrun(underrun));
